/* core/tpm_pkg.sv */
package tpm_pkg;
   localparam int ADR_W = 8;
   localparam int DAT_W = 32;
   localparam int CNT_W = 8;
   localparam int N_CFG = 6;
   localparam int SEL_W = 3;
   // Register byte addresses
   localparam logic [7:0] CFG_COUNT_ADR = 8'h00;
   localparam logic [7:0] CFG_ENTRY_ADR = 8'h04;
   localparam logic [7:0] FIX_COUNT_ADR = 8'h20;
   localparam logic [7:0] FIX_E1_ADR = 8'h24;
   localparam logic [7:0] FIX_E2_ADR = 8'h28;
   localparam logic [7:0] CTRL_ADR = 8'h30;
   localparam logic [7:0] STAT_ADR = 8'h34;
   localparam logic [7:0] REFUSED_ADR_ADR = 8'h38;
   localparam logic [7:0] SM_TYPE_ADR = 8'h3c;
   // Mapping entry field layout
   localparam int SIZE_LSB = 0;
   localparam int SIZE_W = 8;
   localparam int SUB_LSB = 8;
   localparam int SUB_W = 8;
   localparam int INDEX_LSB = 16;
   localparam int INDEX_W = 16;
   // Reset and fixed values
   localparam logic [7:0] CFG_COUNT_RST = 8'h00;
   localparam logic [31:0] CFG_ENTRY_RST = 32'h00000000;
   localparam logic [7:0] FIX_COUNT_VAL = 8'h02;
   localparam logic [31:0] FIX_E1_VAL = 32'h60410010;
   localparam logic [31:0] FIX_E2_RST = 32'h60430010;
   localparam logic [7:0] SM_PD_IN = 8'h04;
   // Status bit positions
   localparam int STAT_REFUSED = 0;
   localparam int STAT_PREOP = 1;
   typedef enum logic [3:0] {
      ST_INIT = 4'h1,
      ST_PREOP = 4'h2,
      ST_SAFEOP = 4'h4,
      ST_OP = 4'h8
   } tpm_state_t;
endpackage : tpm_pkg

/* core/tpm_entry.sv */
`timescale 1ns/1ps
module tpm_entry #(
   parameter int W = 32,
   parameter logic [W-1:0] RST = '0
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic wr_en,
   input wire logic [3:0] sel,
   input wire logic [W-1:0] wdata,
   output logic [W-1:0] q
);
   // Byte lanes follow the bus select bits
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         q <= RST;
      end else if (wr_en) begin
         for (int b = 0; b < W / 8; b++) begin
            if (sel[b]) begin
               q[b*8 +: 8] <= wdata[b*8 +: 8];
            end
         end
      end
   end
endmodule : tpm_entry

/* core/tpm_top.sv */
// The Wishbone slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
// Summary of operation
// R1 - Every mapping entry packs bit size in 7:0, sub-index in 15:8, index in 31:16.
// R2 - Configurable count and entries take writes only in Pre-Operational.
// R3 - The configurable count is 8 bits, resets to zero, and sets the active entries.
// R4 - Six configurable 32-bit entries sit at sub-indices 1 to 6, resetting to zero.
// R5 - The fixed table count is read-only and always reads two.
// R6 - The fixed first entry is read-only and maps the 16-bit object 6041h:0.
// R7 - The fixed second entry defaults to 6043h 16-bit and is writable in Pre-Op.
// R8 - Transmit data built from the mapping goes out on the process data input channel.
// R9 - A refused write leaves storage unchanged and raises a sticky refused flag.
module tpm_top (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_we_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic pd_fixed_i,
   input wire logic [2:0] pd_sel_i,
   output logic pd_valid_o,
   output logic [15:0] pd_index_o,
   output logic [7:0] pd_sub_o,
   output logic [7:0] pd_size_o,
   output logic [7:0] pd_sm_type_o,
   output logic preop_o,
   output logic refused_o
);
   logic ack_reg;
   logic [31:0] dat_reg;
   tpm_pkg::tpm_state_t state_reg;
   logic refused_reg;
   logic [7:0] refused_adr_reg;
   logic [7:0] cfg_count;
   logic [31:0] cfg_entry [tpm_pkg::N_CFG];
   logic [31:0] fix_e2;
   logic req;
   logic wr_req;
   logic rd_req;
   logic [7:0] adr;
   logic preop;
   logic [tpm_pkg::N_CFG-1:0] entry_hit;
   logic cnt_hit;
   logic fe2_hit;
   logic ro_hit;
   logic ctl_hit;
   logic sts_hit;
   logic map_wr_ok;
   logic refused_set;
   logic refused_clr;
   logic state_legal;
   logic [31:0] rd_data;
   logic [31:0] pd_word;
   logic pd_in_range;
   logic pd_valid_reg;
   logic [15:0] pd_index_reg;
   logic [7:0] pd_sub_reg;
   logic [7:0] pd_size_reg;
   logic [7:0] pd_sm_type_reg;

   // One request per bus cycle; ack drops the cycle after it was given
   assign req = wb_cyc_i & wb_stb_i & ~ack_reg;
   assign wr_req = req & wb_we_i;
   assign rd_req = req & ~wb_we_i;
   assign adr = {wb_adr_i[7:2], 2'b00};
   assign preop = (state_reg == tpm_pkg::ST_PREOP);
   assign map_wr_ok = wr_req & preop; // R2

   always_comb begin
      entry_hit = '0;
      cnt_hit = 1'b0;
      fe2_hit = 1'b0;
      ro_hit = 1'b0;
      ctl_hit = 1'b0;
      sts_hit = 1'b0;
      if (adr == tpm_pkg::CFG_COUNT_ADR) begin
         cnt_hit = 1'b1;
      end else if (adr >= tpm_pkg::CFG_ENTRY_ADR &&
                   adr < tpm_pkg::FIX_COUNT_ADR &&
                   adr[4:2] <= 3'h6) begin
         entry_hit[adr[4:2] - 3'h1] = 1'b1; // R4
      end else if (adr == tpm_pkg::FIX_E2_ADR) begin
         fe2_hit = 1'b1;
      end else if (adr == tpm_pkg::FIX_COUNT_ADR ||
                   adr == tpm_pkg::FIX_E1_ADR) begin
         ro_hit = 1'b1; // R5 R6
      end else if (adr == tpm_pkg::CTRL_ADR) begin
         ctl_hit = 1'b1;
      end else if (adr == tpm_pkg::STAT_ADR) begin
         sts_hit = 1'b1;
      end
   end

   // Count field is one byte wide, so only lane 0 can reach it
   tpm_entry #(
      .W(tpm_pkg::CNT_W),
      .RST(tpm_pkg::CFG_COUNT_RST)
   ) u_cfg_count (
      .clock(clock),
      .sys_rst(sys_rst),
      .wr_en(map_wr_ok & cnt_hit), // R2 R3
      .sel(wb_sel_i),
      .wdata(wb_dat_i[7:0]),
      .q(cfg_count)
   );

   for (genvar g = 0; g < tpm_pkg::N_CFG; g++) begin : g_cfg
      tpm_entry #(
         .W(tpm_pkg::DAT_W),
         .RST(tpm_pkg::CFG_ENTRY_RST)
      ) u_entry (
         .clock(clock),
         .sys_rst(sys_rst),
         .wr_en(map_wr_ok & entry_hit[g]), // R2 R4
         .sel(wb_sel_i),
         .wdata(wb_dat_i),
         .q(cfg_entry[g])
      );
   end

   // Fixed second entry stays writable in Pre-Op, as the object table allows
   tpm_entry #(
      .W(tpm_pkg::DAT_W),
      .RST(tpm_pkg::FIX_E2_RST)
   ) u_fix_e2 (
      .clock(clock),
      .sys_rst(sys_rst),
      .wr_en(map_wr_ok & fe2_hit), // R7
      .sel(wb_sel_i),
      .wdata(wb_dat_i),
      .q(fix_e2)
   );

   always_comb begin
      state_legal = 1'b0;
      case (wb_dat_i[3:0])
         tpm_pkg::ST_INIT,
         tpm_pkg::ST_PREOP,
         tpm_pkg::ST_SAFEOP,
         tpm_pkg::ST_OP: state_legal = 1'b1;
         default: state_legal = 1'b0;
      endcase
   end

   // Slave state; codes that are not one-hot are dropped
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         state_reg <= tpm_pkg::ST_INIT;
      end else if (wr_req & ctl_hit & wb_sel_i[0] & state_legal) begin
         state_reg <= tpm_pkg::tpm_state_t'(wb_dat_i[3:0]);
      end
   end

   assign refused_set = wr_req &
      (((cnt_hit | fe2_hit | (|entry_hit)) & ~preop) | ro_hit); // R9
   assign refused_clr = wr_req & sts_hit & wb_sel_i[0] &
      wb_dat_i[tpm_pkg::STAT_REFUSED];

   // Set wins over a write-one clear in the same cycle
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         refused_reg <= 1'b0;
      end else if (refused_set) begin
         refused_reg <= 1'b1; // R9
      end else if (refused_clr) begin
         refused_reg <= 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         refused_adr_reg <= 8'h00;
      end else if (refused_set) begin
         refused_adr_reg <= adr; // R9
      end
   end

   always_comb begin
      rd_data = 32'h00000000;
      if (cnt_hit) begin
         rd_data = {24'h000000, cfg_count}; // R3
      end else if (|entry_hit) begin
         rd_data = cfg_entry[adr[4:2] - 3'h1]; // R4
      end else if (adr == tpm_pkg::FIX_COUNT_ADR) begin
         rd_data = {24'h000000, tpm_pkg::FIX_COUNT_VAL}; // R5
      end else if (adr == tpm_pkg::FIX_E1_ADR) begin
         rd_data = tpm_pkg::FIX_E1_VAL; // R6
      end else if (fe2_hit) begin
         rd_data = fix_e2; // R7
      end else if (ctl_hit) begin
         rd_data = {28'h0000000, state_reg};
      end else if (sts_hit) begin
         rd_data = {30'h00000000, preop, refused_reg};
      end else if (adr == tpm_pkg::REFUSED_ADR_ADR) begin
         rd_data = {24'h000000, refused_adr_reg};
      end else if (adr == tpm_pkg::SM_TYPE_ADR) begin
         rd_data = {24'h000000, pd_sm_type_reg}; // R8
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= req;
      end
   end

   // Unmapped reads answer zero rather than stalling the master
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         dat_reg <= 32'h00000000;
      end else if (rd_req) begin
         dat_reg <= rd_data;
      end
   end

   // Process data lookup for the frame builder
   always_comb begin
      pd_word = 32'h00000000;
      pd_in_range = 1'b0;
      if (pd_fixed_i) begin
         pd_word = (pd_sel_i == 3'h0) ? tpm_pkg::FIX_E1_VAL : fix_e2;
         pd_in_range = {5'h00, pd_sel_i} < tpm_pkg::FIX_COUNT_VAL;
      end else if (pd_sel_i < 3'h6) begin
         pd_word = cfg_entry[pd_sel_i];
         pd_in_range = {5'h00, pd_sel_i} < cfg_count; // R3
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         pd_valid_reg <= 1'b0;
         pd_index_reg <= 16'h0000;
         pd_sub_reg <= 8'h00;
         pd_size_reg <= 8'h00;
      end else begin
         pd_valid_reg <= pd_in_range;
         pd_index_reg <= pd_word[tpm_pkg::INDEX_LSB +: tpm_pkg::INDEX_W]; // R1
         pd_sub_reg <= pd_word[tpm_pkg::SUB_LSB +: tpm_pkg::SUB_W]; // R1
         pd_size_reg <= pd_word[tpm_pkg::SIZE_LSB +: tpm_pkg::SIZE_W]; // R1
      end
   end

   // Transmit data always leaves on the slave-to-master channel
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         pd_sm_type_reg <= 8'h00;
      end else begin
         pd_sm_type_reg <= tpm_pkg::SM_PD_IN; // R8
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = dat_reg;
   assign pd_valid_o = pd_valid_reg;
   assign pd_index_o = pd_index_reg;
   assign pd_sub_o = pd_sub_reg;
   assign pd_size_o = pd_size_reg;
   assign pd_sm_type_o = pd_sm_type_reg;
   // One-hot state, so the Pre-Op bit is itself the flag
   assign preop_o = state_reg[1];
   assign refused_o = refused_reg;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (sys_rst);

   sequence s_req_wr;
      wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
   endsequence

   sequence s_req_rd(logic [7:0] a);
      wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o &&
         {wb_adr_i[7:2], 2'b00} == a;
   endsequence

   ack_single_cycle_a: assert property (
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");

   ack_latency_a: assert property (
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack not given one cycle after request");

   blocked_write_a: assert property ( // R2
      s_req_wr ##0 (!preop && (cnt_hit || (|entry_hit)))
      |=> $stable(cfg_count) && $stable(cfg_entry[0]))
      else $error("mapping changed outside Pre-Operational");

   count_reset_a: assert property ( // R3
      $fell(sys_rst) |-> cfg_count == 8'h00 && cfg_entry[5] == 32'h0)
      else $error("configurable table not cleared by reset");

   entry_write_a: assert property ( // R4
      s_req_wr ##0 (preop && entry_hit[0] && wb_sel_i == 4'hf)
      |=> cfg_entry[0] == $past(wb_dat_i))
      else $error("entry one did not take a Pre-Op write");

   fixed_count_a: assert property ( // R5
      s_req_rd(8'h20) |=> wb_ack_o && wb_dat_o == 32'h00000002)
      else $error("fixed count did not read two");

   fixed_first_a: assert property ( // R6
      s_req_rd(8'h24) |=> wb_ack_o && wb_dat_o == 32'h60410010)
      else $error("fixed first entry read wrong");

   fixed_second_a: assert property ( // R7
      $fell(sys_rst) |-> fix_e2 == 32'h60430010)
      else $error("fixed second entry default wrong");

   sm_channel_a: assert property ( // R8
      !$past(sys_rst) |-> pd_sm_type_o == 8'h04)
      else $error("process data channel type is not input");

   refused_flag_a: assert property ( // R9
      s_req_wr ##0 ro_hit |=> refused_o ##1 (refused_o || $past(refused_clr)))
      else $error("refused write not flagged");

   field_split_a: assert property ( // R1
      !pd_fixed_i && pd_sel_i == 3'h0 |=>
      {pd_index_o, pd_sub_o, pd_size_o} == $past(cfg_entry[0]))
      else $error("entry fields split wrongly");
endmodule : tpm_top

/* bench/tpm_master.sv */
`timescale 1ns/1ps
// Bus master in the network master's place
module tpm_master (
   input wire logic clock,
   input wire logic ack,
   input wire logic [31:0] rdat,
   output logic cyc,
   output logic stb,
   output logic we,
   output logic [7:0] adr,
   output logic [31:0] wdat,
   output logic [3:0] sel
);
   initial begin
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 8'h00;
      wdat = 32'h00000000;
      sel = 4'h0;
   end
   // Enter just after a rising edge; no fixed latency is assumed
   task automatic xfer(input logic [7:0] a, input logic [31:0] d,
                       input logic w, output logic [31:0] q);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= 4'hf;
      do @(posedge clock); while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      // Address and write data lines change on release, so a stale value can never pass
      adr <= ~a;
      wdat <= ~d;
      @(posedge clock);
   endtask : xfer
endmodule : tpm_master

/* bench/tb.sv */
`timescale 1ns/1ps
module tb;
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic pd_fixed_i = 1'b0;
   logic [2:0] pd_sel_i = 3'h0;
   logic cyc, stb, we, ack, pd_valid_o, preop_o, refused_o;
   logic [7:0] adr, pd_sub_o, pd_size_o, pd_sm_type_o;
   logic [15:0] pd_index_o;
   logic [31:0] wdat, rdat, q;
   logic [3:0] sel;
   int err_total = 0;
   int cmp_count = 0;
   int cyc_n = 0;
   always #5 clock = ~clock;
   tpm_top u_tpm_top (.clock(clock), .sys_rst(sys_rst), .wb_adr_i(adr),
      .wb_dat_i(wdat), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack),
      .pd_fixed_i(pd_fixed_i), .pd_sel_i(pd_sel_i), .pd_valid_o(pd_valid_o),
      .pd_index_o(pd_index_o), .pd_sub_o(pd_sub_o), .pd_size_o(pd_size_o),
      .pd_sm_type_o(pd_sm_type_o), .preop_o(preop_o),
      .refused_o(refused_o));
   tpm_master u_tpm_master (.clock(clock), .ack(ack), .rdat(rdat),
      .cyc(cyc), .stb(stb), .we(we), .adr(adr), .wdat(wdat), .sel(sel));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic give_verdict;
      if (err_total == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : give_verdict
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      u_tpm_master.xfer(a, d, 1'b1, q);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      u_tpm_master.xfer(a, 32'h00000000, 1'b0, q);
      chk(q, exp);
   endtask : rd
   function automatic logic [31:0] ent(input int i);
      return {16'h6000 + 16'(i), 8'(i), 8'h10};
   endfunction : ent
   task automatic pd_chk(input logic f, input logic [2:0] s,
                         input logic v, input logic [31:0] x);
      pd_fixed_i <= f;
      pd_sel_i <= s;
      repeat (2) @(posedge clock);
      chk({31'h0, pd_valid_o}, {31'h0, v});
      chk({pd_index_o, pd_sub_o, pd_size_o}, x);
   endtask : pd_chk
   // Ceiling well above the roughly two hundred cycles the sequence needs
   always @(posedge clock) begin
      cyc_n++;
      if (cyc_n == 3000) begin
         err_total++;
         give_verdict();
      end
   end
   initial begin
      repeat (10) @(posedge clock);
      sys_rst <= 1'b0;
      @(posedge clock);
      rd(8'h00, 32'h0);
      for (int i = 1; i <= 6; i++) rd(8'(4 * i), 32'h0);
      rd(8'h20, 32'h2);
      rd(8'h24, 32'h60410010);
      rd(8'h28, 32'h60430010);
      rd(8'h3c, 32'h4);
      chk({24'h0, pd_sm_type_o}, 32'h4);
      // Init state bounces mapping writes
      wr(8'h04, 32'h12345678);
      rd(8'h04, 32'h0);
      chk({31'h0, refused_o}, 32'h1);
      rd(8'h38, 32'h4);
      wr(8'h34, 32'h1);
      chk({31'h0, refused_o}, 32'h0);
      wr(8'h30, 32'h2);
      chk({31'h0, preop_o}, 32'h1);
      wr(8'h00, 32'h3);
      for (int i = 1; i <= 6; i++) wr(8'(4 * i), ent(i));
      for (int i = 1; i <= 6; i++) rd(8'(4 * i), ent(i));
      rd(8'h00, 32'h3);
      wr(8'h20, 32'h5);
      wr(8'h24, 32'h0);
      rd(8'h20, 32'h2);
      rd(8'h24, 32'h60410010);
      chk({31'h0, refused_o}, 32'h1);
      rd(8'h34, 32'h3);
      wr(8'h28, 32'h60440020);
      rd(8'h28, 32'h60440020);
      for (int i = 0; i < 8; i++) begin
         pd_chk(1'b0, 3'(i), i < 3, i < 6 ? ent(i + 1) : 32'h0);
      end
      pd_chk(1'b1, 3'h0, 1'b1, 32'h60410010);
      pd_chk(1'b1, 3'h1, 1'b1, 32'h60440020);
      // Operational freezes the whole configuration
      wr(8'h30, 32'h8);
      chk({31'h0, preop_o}, 32'h0);
      // A code that is not one-hot must leave the state alone
      wr(8'h30, 32'h3);
      rd(8'h30, 32'h8);
      wr(8'h34, 32'h1);
      wr(8'h08, 32'h0);
      wr(8'h00, 32'h6);
      wr(8'h28, 32'h0);
      rd(8'h08, ent(2));
      rd(8'h00, 32'h3);
      rd(8'h28, 32'h60440020);
      chk({31'h0, refused_o}, 32'h1);
      // Safe-Operational freezes the mapping as well
      wr(8'h30, 32'h4);
      wr(8'h04, 32'h0);
      rd(8'h04, ent(1));
      // A second reset mid-run must restore every default
      sys_rst <= 1'b1;
      repeat (2) @(posedge clock);
      sys_rst <= 1'b0;
      @(posedge clock);
      chk({31'h0, refused_o}, 32'h0);
      chk({31'h0, preop_o}, 32'h0);
      rd(8'h00, 32'h0);
      rd(8'h18, 32'h0);
      rd(8'h28, 32'h60430010);
      chk({24'h0, pd_sm_type_o}, 32'h4);
      give_verdict();
   end
endmodule : tb
